/* File: supervisor_pkg.sv */
// constants and types shared by the supply supervisor and its input filter
package supervisor_pkg;

    // timebase
    localparam int CLK_FREQ_KHZ     = 125000;

    // documented times in their own units
    localparam int HOLD_TIME_MS     = 200;
    localparam int WD_PERIOD_MS     = 1600;
    localparam int WD_PULSE_MIN_NS  = 50;
    localparam int DEBOUNCE_TIME_NS = 1000;

    // cycle counts derived from the times; the hold and period values are exact
    localparam int HOLD_CYCLES      = HOLD_TIME_MS * CLK_FREQ_KHZ;
    localparam int WD_CYCLES        = WD_PERIOD_MS * CLK_FREQ_KHZ;
    localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int WD_PULSE_CYCLES  = (WD_PULSE_MIN_NS * CLK_FREQ_KHZ + 999999) / 1000000;

    // counter widths
    localparam int CNT_W            = 28;
    localparam int DB_CNT_W         = 8;

    // reset values
    localparam logic MANUAL_IDLE_LEVEL = 1'b1;
    localparam logic WD_IDLE_LEVEL     = 1'b0;

    // reset output states, gray coded
    typedef enum logic [1:0] {
        STATE_HOLD = 2'b00,
        STATE_RUN  = 2'b01
    } sup_state_e;

endpackage : supervisor_pkg

/* File: mr_debounce.sv */
// contact bounce filter for the manual reset input
`timescale 1ns/100ps
module manual_debounce #(
    parameter int STABLE_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // raw and filtered level
    input  wire logic raw_level,
    output logic      clean_level
);
    import supervisor_pkg::*;

    localparam logic [DB_CNT_W-1:0] LAST = DB_CNT_W'(STABLE_CYCLES - 1);

    typedef struct packed {
        logic                level;
        logic [DB_CNT_W-1:0] cnt;
    } db_state_s;

    localparam db_state_s DB_RESET = '{level: MANUAL_IDLE_LEVEL, cnt: '0};

    db_state_s cur;
    db_state_s next_cur;

    ////////////////////////////////////////////////////////////////////////////
    // a new level is taken only after it stood for the full window
    always_comb begin
        next_cur = cur;
        if (raw_level == cur.level) begin
            next_cur.cnt = '0;                         // bounce restarts the window
        end else if (cur.cnt == LAST) begin
            next_cur.level = raw_level;
            next_cur.cnt   = '0;
        end else begin
            next_cur.cnt = cur.cnt + DB_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur <= DB_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign clean_level = cur.level;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_DB_STABLE: assert property (@(posedge clk_sys) disable iff (srst)
        $changed(cur.level) |-> $past(cur.cnt) == LAST)
        else $error("filtered level changed before the window ran out");

endmodule : manual_debounce

/* File: supervisor_reset_watchdog.sv */
// supply supervisor with reset hold timer, manual reset and watchdog
`timescale 1ns/100ps

// Overview of operation
// - Reset on low supply, watchdog, manual
// - Power-up holds reset full hold time
// - Every reset lasts full hold time
// - Low supply clears hold timer
// - Open-drain line driven low only in reset
// - Manual low holds reset, then hold time
// - Undriven manual input counts as high
// - Manual input debounced internally
// - No watchdog edge within period resets
// - Reset or any edge clears watchdog
// - Watchdog cleared during reset, counts after
// - Floating watchdog input never times out
// - Internal low-high-low pulse services floating input
// - Watchdog reset also holds full time
// - Active-high output inverse of active-low
module supervisor_reset_watchdog #(
    parameter int HOLD_CYCLES     = supervisor_pkg::HOLD_CYCLES,
    parameter int WD_CYCLES       = supervisor_pkg::WD_CYCLES,
    parameter int DEBOUNCE_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // supply comparator, high while supply is below trip level
    input  wire logic supply_low,
    // manual reset pin and whether anything drives it
    input  wire logic manual_reset_n,
    input  wire logic manual_reset_drive,
    // watchdog pin and whether anything drives it
    input  wire logic watchdog_toggle_in,
    input  wire logic watchdog_drive,
    // reset outputs
    output logic      reset_out_n,
    output logic      reset_out,
    output logic      reset_od_out,
    output logic      reset_od_oe
);
    import supervisor_pkg::*;

    // counts held at counter width, from the parameters
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WD_HALF   = CNT_W'(WD_CYCLES / 2);

    typedef struct packed {
        sup_state_e       state;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] wd_cnt;
        logic             wd_prev;
        logic             service;
        logic             supply_meta;
        logic             supply_sync;
    } sup_s;

    // everything comes back to a fresh hold on srst
    localparam sup_s SUP_RESET = '{
        state:       STATE_HOLD,
        hold_cnt:    '0,
        wd_cnt:      '0,
        wd_prev:     WD_IDLE_LEVEL,
        service:     1'b0,
        supply_meta: 1'b0,
        supply_sync: 1'b0
    };

    // cur is the whole state, next_cur its value for the coming edge
    sup_s cur;
    sup_s next_cur;
    // decoded helpers, combinational from cur and the pins, except manual_level, which comes from the debouncer register
    logic manual_raw;
    logic manual_level;
    logic wd_level;
    logic wd_edge;
    logic hold_cause;
    logic asserted;

    ////////////////////////////////////////////////////////////////////////////
    // input conditioning
    assign manual_raw = manual_reset_drive ? manual_reset_n : MANUAL_IDLE_LEVEL; // pull-up

    manual_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_manual_debounce (
        .clk_sys     (clk_sys),
        .srst        (srst),
        .raw_level   (manual_raw),
        .clean_level (manual_level)
    );

    // a floating watchdog pin is replaced by the internal service pulse
    assign wd_level   = watchdog_drive ? watchdog_toggle_in : cur.service;
    assign wd_edge    = wd_level ^ cur.wd_prev;                            // both edges
    assign hold_cause = cur.supply_sync | ~manual_level;
    assign asserted   = (cur.state == STATE_HOLD);

    ////////////////////////////////////////////////////////////////////////////
    // reset state, hold timer and watchdog counter
    always_comb begin
        next_cur             = cur;
        next_cur.supply_meta = supply_low;                 // two-flop sync
        next_cur.supply_sync = cur.supply_meta;            // only reader of the first flop
        next_cur.wd_prev     = wd_level;
        next_cur.service     = 1'b0;
        // illegal codes are caught by the default branch
        unique case (cur.state)
            STATE_HOLD: begin
                next_cur.wd_cnt = '0;                      // held clear in reset
                if (hold_cause) begin
                    next_cur.hold_cnt = '0;                // timer restarts
                end else if (cur.hold_cnt == HOLD_LAST) begin
                    next_cur.state    = STATE_RUN;         // full hold elapsed
                    next_cur.hold_cnt = '0;
                end else begin
                    next_cur.hold_cnt = cur.hold_cnt + CNT_W'(1);
                end
            end
            STATE_RUN: begin
                if (hold_cause) begin
                    next_cur.state  = STATE_HOLD;
                    next_cur.wd_cnt = '0;
                end else if (wd_edge) begin
                    next_cur.wd_cnt = '0;                  // edge beats a timeout
                end else if (cur.wd_cnt == WD_LAST) begin
                    next_cur.state  = STATE_HOLD;          // timeout, then full hold
                    next_cur.wd_cnt = '0;
                end else begin
                    next_cur.wd_cnt = cur.wd_cnt + CNT_W'(1);
                    // pulse from the half-period point on, so a pin that is let go late
                    // in a period is still serviced before the count runs out
                    next_cur.service = ~watchdog_drive && (cur.wd_cnt >= WD_HALF);
                end
            end
            default: begin
                // an illegal code falls back to a fresh hold rather than lock up
                next_cur.state    = STATE_HOLD;
                next_cur.hold_cnt = '0;
                next_cur.wd_cnt   = '0;
            end
        endcase
    end

    // one register for all state keeps the reset branch in one place
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur <= SUP_RESET;                              // power-up starts in hold
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all but the constant reset_od_out straight from the state register
    assign reset_out_n  = ~asserted;
    assign reset_out    = asserted;
    assign reset_od_out = 1'b0;                            // line only ever pulled low
    assign reset_od_oe  = asserted;                        // released otherwise

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SUPPLY_RESET: assert property (@(posedge clk_sys) disable iff (srst)
        supply_low |-> ##3 reset_out)
        else $error("low supply did not assert reset in three cycles");

    AST_SUPPLY_CLEARS: assert property (@(posedge clk_sys) disable iff (srst)
        cur.supply_sync |=> cur.hold_cnt == '0 && reset_out)
        else $error("hold timer ran while supply was low");

    AST_FULL_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(reset_out) |-> $past(cur.hold_cnt) == HOLD_LAST && !$past(hold_cause))
        else $error("reset released before the full hold time");

    AST_HOLD_STEP: assert property (@(posedge clk_sys) disable iff (srst)
        reset_out && !hold_cause && cur.hold_cnt != HOLD_LAST
        |=> reset_out && cur.hold_cnt == $past(cur.hold_cnt) + CNT_W'(1))
        else $error("hold timer did not advance while no cause was present");

    AST_MANUAL_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        !manual_level |=> reset_out && cur.hold_cnt == '0)
        else $error("manual reset low did not hold reset");

    AST_WD_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
        reset_out |-> cur.wd_cnt == '0)
        else $error("watchdog counted during reset");

    AST_WD_START: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(reset_out) && !hold_cause && !wd_edge |=> cur.wd_cnt == CNT_W'(1))
        else $error("watchdog did not start counting at release");

    AST_WD_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
        !reset_out && !hold_cause && wd_edge |=> !reset_out && cur.wd_cnt == '0)
        else $error("watchdog edge did not clear the counter");

    AST_WD_TIMEOUT: assert property (@(posedge clk_sys) disable iff (srst)
        !reset_out && !wd_edge && cur.wd_cnt == WD_LAST |=> reset_out && cur.hold_cnt == '0)
        else $error("watchdog timeout did not assert reset");

    AST_WD_FLOAT: assert property (@(posedge clk_sys) disable iff (srst)
        !watchdog_drive && !reset_out |-> cur.wd_cnt <= WD_HALF + CNT_W'(2))
        else $error("floating watchdog ran past its service point");

    AST_SERVICE_ONE: assert property (@(posedge clk_sys) disable iff (srst)
        cur.service |=> !cur.service)
        else $error("internal service pulse lasted more than one cycle");

    AST_OUT_PAIR: assert property (@(posedge clk_sys) disable iff (srst)
        reset_out != reset_out_n && reset_od_oe == !reset_out_n && !reset_od_out)
        else $error("reset outputs disagree");

    // covers mark the main scenarios that the bench should reach
    COV_RELEASE:  cover property (@(posedge clk_sys) disable iff (srst) $fell(reset_out));
    COV_WD_TRIP:  cover property (@(posedge clk_sys) disable iff (srst)
        !reset_out && !wd_edge && !hold_cause && cur.wd_cnt == WD_LAST);
    COV_SERVICE:  cover property (@(posedge clk_sys) disable iff (srst) cur.service);
    COV_MANUAL:   cover property (@(posedge clk_sys) disable iff (srst)
        !reset_out ##1 !manual_level);

endmodule : supervisor_reset_watchdog

/* File: mcu_model.sv */
// host model: pulses the watchdog pin, or lets it float
`timescale 1ns/100ps
module mcu_model #(
    parameter int GAP = 30
) (
    // clock and reset seen by the host
    input  wire logic clk_sys,
    input  wire logic reset_out_n,
    // bench controls
    input  wire logic svc_en,
    input  wire logic float_en,
    // watchdog pin
    output logic      watchdog_toggle_in,
    output logic      watchdog_drive
);
    int   cnt = 0;
    logic lvl = 1'b0;

    // short high pulses keep pin current low; quiet while in reset
    always @(posedge clk_sys) begin
        cnt <= (cnt == GAP - 1 || !reset_out_n) ? 0 : cnt + 1;
        if (!float_en) begin
            lvl <= svc_en && reset_out_n && (cnt < 7);
        end
    end

    // a released pin shows the inverse of its last level, not a held one
    assign watchdog_drive     = !float_en;
    assign watchdog_toggle_in = float_en ? !lvl : lvl;
endmodule : mcu_model

/* File: supervisor_reset_watchdog_tb_top.sv */
// self-checking bench for the supervisor with a host model
`timescale 1ns/100ps
module supervisor_reset_watchdog_tb_top;
    localparam int HOLD = 40;
    localparam int WD   = 100;
    localparam int DB   = 4;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic supply_low = 1'b0;
    logic manual_reset_n = 1'b1;
    logic manual_reset_drive = 1'b1;
    logic svc_en = 1'b1;
    logic float_en = 1'b0;
    logic watchdog_toggle_in, watchdog_drive;
    logic reset_out_n, reset_out, reset_od_out, reset_od_oe;
    int   err_count = 0;
    int   checked = 0;
    int   cycles = 0;
    int   n;

    always #4 clk_sys = ~clk_sys;

    // short counts keep the run brief
    supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD), .DEBOUNCE_CYCLES(DB))
        i_supervisor_reset_watchdog (.clk_sys(clk_sys), .srst(srst),
        .supply_low(supply_low), .manual_reset_n(manual_reset_n),
        .manual_reset_drive(manual_reset_drive), .watchdog_toggle_in(watchdog_toggle_in),
        .watchdog_drive(watchdog_drive), .reset_out_n(reset_out_n), .reset_out(reset_out),
        .reset_od_out(reset_od_out), .reset_od_oe(reset_od_oe));
    mcu_model i_mcu_model (.clk_sys(clk_sys), .reset_out_n(reset_out_n), .svc_en(svc_en),
        .float_en(float_en), .watchdog_toggle_in(watchdog_toggle_in),
        .watchdog_drive(watchdog_drive));

    //////////////////////////////////////////////////////////////////////
    task automatic check(input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // inputs change 1 ns after the edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic outs(input logic on);
        check(reset_out_n, !on);
        check(reset_out, on);
        check(reset_od_oe, on);
        check(reset_od_out, 1'b0);
    endtask : outs
    // bounded wait, n counts the cycles taken
    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (reset_out_n !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_lvl
    // n counts cycles with reset asserted
    task automatic quiet(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            if (reset_out_n !== 1'b1) n++;
        end
    endtask : quiet
    task automatic t_powerup;
        tick(5);
        outs(1'b1);
        srst = 1'b0;
        wait_lvl(1'b1, HOLD + 10);
        check(n >= HOLD && n <= HOLD + 4, 1'b1);
        outs(1'b0);
    endtask : t_powerup
    // a second dip mid-hold must restart the timer
    task automatic t_supply;
        supply_low = 1'b1;
        tick(4);
        outs(1'b1);
        supply_low = 1'b0;
        tick(20);
        supply_low = 1'b1;
        tick(2);
        supply_low = 1'b0;
        wait_lvl(1'b1, HOLD + 10);
        check(n >= HOLD + 1 && n <= HOLD + 6, 1'b1);
    endtask : t_supply
    task automatic t_manual;
        repeat (3) begin
            manual_reset_n = 1'b0;
            tick(DB - 2);
            manual_reset_n = 1'b1;
            tick(2);
        end
        manual_reset_drive = 1'b0;
        manual_reset_n = 1'b0;
        quiet(20);
        check(n == 0, 1'b1);
        manual_reset_drive = 1'b1;
        tick(DB + 3);
        outs(1'b1);
        tick(30);
        outs(1'b1);
        manual_reset_n = 1'b1;
        wait_lvl(1'b1, HOLD + DB + 10);
        check(n >= HOLD + DB && n <= HOLD + DB + 4, 1'b1);
    endtask : t_manual
    task automatic t_watchdog;
        svc_en = 1'b0;
        wait_lvl(1'b0, WD + 10);
        check(n >= WD && n <= WD + 3, 1'b1);
        wait_lvl(1'b1, HOLD + 10);
        check(n >= HOLD && n <= HOLD + 3, 1'b1);
        svc_en = 1'b1;
        quiet(3 * WD);
        check(n == 0, 1'b1);
        float_en = 1'b1;
        quiet(4 * WD);
        check(n == 0, 1'b1);
    endtask : t_watchdog
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // hang guard, well above the expected length of the run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        t_powerup();
        t_supply();
        t_manual();
        t_watchdog();
        give_verdict();
    end
endmodule : supervisor_reset_watchdog_tb_top
